// [logic/asu_cfg.svh]
// Offsets, field positions, reset values and timing counts of the
// audio serial unit data path. Assumes a 100 MHz system clock.
`ifndef ASU_CFG_SVH
`define ASU_CFG_SVH
`define ASU_CLK_MHZ      100
`define ASU_BCLK_NS      160
`define ASU_BCLK_HALF    ((`ASU_BCLK_NS * `ASU_CLK_MHZ) / 2000)
`define ASU_OFS_RXFIFO   6'h00
`define ASU_OFS_RXDMA0   6'h04
`define ASU_OFS_TXFIFO   6'h14
`define ASU_OFS_TXDMA0   6'h18
`define ASU_OFS_CTRL     6'h28
`define ASU_OFS_DMAEN    6'h2C
`define ASU_OFS_STAT     6'h30
`define ASU_OFS_CLK      6'h34
`define ASU_CTL_EN       0
`define ASU_CTL_W16      1
`define ASU_CTL_NET      2
`define ASU_CTL_SYNC     3
`define ASU_CTL_TXINT    4
`define ASU_CTL_RXINT    5
`define ASU_CTL_NSL      7:6
`define ASU_CTL_TXSL     11:8
`define ASU_CTL_RXSL     15:12
`define ASU_ST_TXU       0
`define ASU_ST_RXO       1
`define ASU_CTRL_RST     16'h0000
`define ASU_DMAEN_RST    8'h00
`define ASU_FLEN_RST     7'h1F
`endif

// [logic/asu_pkg.sv]
// Types shared by the audio serial unit data path.
// Assumes asu_cfg.svh for all numeric constants.
package asu_pkg;
  typedef logic [15:0] asu_word_t;
  typedef logic [3:0]  asu_ptr_t;
  typedef logic [1:0]  asu_slot_t;
endpackage : asu_pkg

// [logic/asu_datapath.sv]
// Audio serial unit data path: shifters, FIFOs, slot DMA holding registers.
// Assumes a plain register port on clk and codec pins from another domain.
//
// Function
// - Load next tx word, then advance read pointer
// - Bus write stores at write pointer, advances
// - Tx empty: pointers equal, last access read
// - Underrun steps read pointer back, resends word
// - Underrun sets sticky flag, no interrupt
// - Clock and sync internal or external per direction
// - Rx samples on falling clock; sync mode uses tx
// - Normal rx DMA fills holding 0, overwrites
// - Rx word stored at write pointer, advances
// - Bus read returns read pointer entry, advances
// - Full rx FIFO drops word, sets overrun
// - Network frame has up to four assignable slots
// - Tx pin driven only in assigned slots
// - Network tx DMA per slot, resend when empty
// - Network tx FIFO gives one entry per word
// - Rx captures all slots, passes assigned only
// - Network rx DMA per slot, overwrite when full
// - Eight or sixteen bit words, low bits used
// - Tx shifts out on rising clock after sync
// - Normal tx DMA from holding 0, resend empty
// - FIFOs hold sixteen 16-bit entries
// - Per-slot DMA enable selects FIFO or holding
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "asu_cfg.svh"
module asu_datapath #(
  parameter int DEPTH     = 16,
  parameter int BCLK_HALF = `ASU_BCLK_HALF
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [5:0]      addr,
  input  wire asu_pkg::asu_word_t wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output asu_pkg::asu_word_t   rdata,
  input  wire logic            tx_shift_clock_pin_i,
  output logic                 tx_shift_clock_pin_o,
  output logic                 tx_shift_clock_pin_oe,
  input  wire logic            tx_frame_sync_pin_i,
  output logic                 tx_frame_sync_pin_o,
  output logic                 tx_frame_sync_pin_oe,
  input  wire logic            rx_shift_clock_pin_i,
  output logic                 rx_shift_clock_pin_o,
  output logic                 rx_shift_clock_pin_oe,
  input  wire logic            rx_frame_sync_pin_i,
  output logic                 rx_frame_sync_pin_o,
  output logic                 rx_frame_sync_pin_oe,
  output logic                 serial_tx_data_pin_o,
  output logic                 serial_tx_data_pin_oe,
  input  wire logic            serial_rx_data_pin_i,
  output logic [3:0]           tx_dma_req,
  output logic [3:0]           rx_dma_req
);
  import asu_pkg::*;

  if (DEPTH != 16 || BCLK_HALF < 1 || BCLK_HALF > 255) begin : g_param_check
    $error("asu_datapath: unsupported parameters");
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  asu_word_t   ctrl_reg;
  logic [7:0]  dmaen_reg;
  logic [6:0]  flen_reg;
  logic        txu_reg, rxo_reg;
  logic        en, w16, net, syn, tx_int, rx_int;
  logic [1:0]  nsl;
  logic [3:0]  tx_asg, rx_asg;
  assign en     = ctrl_reg[`ASU_CTL_EN];
  assign w16    = ctrl_reg[`ASU_CTL_W16];
  assign net    = ctrl_reg[`ASU_CTL_NET];
  assign syn    = ctrl_reg[`ASU_CTL_SYNC];
  assign tx_int = ctrl_reg[`ASU_CTL_TXINT];
  assign rx_int = ctrl_reg[`ASU_CTL_RXINT];
  // Normal mode is one frame of one slot, always slot 0
  assign nsl    = net ? ctrl_reg[`ASU_CTL_NSL] : 2'h0;
  assign tx_asg = net ? ctrl_reg[`ASU_CTL_TXSL] : 4'h1;
  assign rx_asg = net ? ctrl_reg[`ASU_CTL_RXSL] : 4'h1;

  logic wr_ctrl, wr_stat, wr_txf, rd_rxf;
  assign wr_ctrl = wr && addr == `ASU_OFS_CTRL;
  assign wr_stat = wr && addr == `ASU_OFS_STAT;
  assign wr_txf  = wr && addr == `ASU_OFS_TXFIFO;
  assign rd_rxf  = rd && addr == `ASU_OFS_RXFIFO;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= `ASU_CTRL_RST;
      dmaen_reg <= `ASU_DMAEN_RST;
      flen_reg  <= `ASU_FLEN_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdata;
    end else if (wr && addr == `ASU_OFS_DMAEN) begin
      dmaen_reg <= wdata[7:0];
    end else if (wr && addr == `ASU_OFS_CLK) begin
      flen_reg <= wdata[6:0];
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers and internal clock generator
  // ------------------------------------------------------------
  logic [4:0] s1_reg, s2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
    end else begin
      s1_reg <= {serial_rx_data_pin_i, rx_frame_sync_pin_i, rx_shift_clock_pin_i,
                 tx_frame_sync_pin_i, tx_shift_clock_pin_i};
      s2_reg <= s1_reg;
    end
  end

  logic [7:0] div_reg;
  logic [6:0] fcnt_reg;
  logic       iclk_reg, ifs_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= 8'h00;
      iclk_reg <= 1'b0;
      ifs_reg  <= 1'b0;
      fcnt_reg <= 7'h00;
    end else if (!en) begin
      div_reg  <= 8'h00;
      iclk_reg <= 1'b0;
      ifs_reg  <= 1'b0;
      fcnt_reg <= 7'h00;
    end else if (div_reg == 8'(BCLK_HALF - 1)) begin
      div_reg  <= 8'h00;
      iclk_reg <= !iclk_reg;
      // Sync changes on the falling edge, one bit period wide
      if (iclk_reg) begin
        ifs_reg  <= fcnt_reg == 7'h00;
        fcnt_reg <= (fcnt_reg == flen_reg) ? 7'h00 : fcnt_reg + 7'h01;
      end
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  logic tck, tfs, rck, rfs, rxd;
  assign tck = tx_int ? iclk_reg : s2_reg[0];
  assign tfs = tx_int ? ifs_reg : s2_reg[1];
  assign rck = syn ? tck : (rx_int ? iclk_reg : s2_reg[2]);
  assign rfs = syn ? tfs : (rx_int ? ifs_reg : s2_reg[3]);
  assign rxd = s2_reg[4];

  assign tx_shift_clock_pin_o  = iclk_reg;
  assign tx_frame_sync_pin_o   = ifs_reg;
  assign tx_shift_clock_pin_oe = en && tx_int;
  assign tx_frame_sync_pin_oe  = en && tx_int;
  assign rx_shift_clock_pin_o  = iclk_reg;
  assign rx_frame_sync_pin_o   = ifs_reg;
  assign rx_shift_clock_pin_oe = en && rx_int && !syn;
  assign rx_frame_sync_pin_oe  = en && rx_int && !syn;

  logic tck_d_reg, rck_d_reg, tfs_seen_reg, rfs_seen_reg;
  logic t_rise, r_rise, r_fall, t_start, r_start;
  assign t_rise  = en && tck && !tck_d_reg;
  assign r_rise  = en && rck && !rck_d_reg;
  assign r_fall  = en && !rck && rck_d_reg;
  // A frame begins at the first rising edge after sync falls
  assign t_start = t_rise && tfs_seen_reg && !tfs;
  assign r_start = r_rise && rfs_seen_reg && !rfs;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_d_reg    <= 1'b0;
      rck_d_reg    <= 1'b0;
      tfs_seen_reg <= 1'b0;
      rfs_seen_reg <= 1'b0;
    end else begin
      tck_d_reg <= tck;
      rck_d_reg <= rck;
      if (t_rise) tfs_seen_reg <= tfs;
      if (r_rise) rfs_seen_reg <= rfs;
    end
  end

  // ------------------------------------------------------------
  // Transmit FIFO and slot holding registers
  // ------------------------------------------------------------
  asu_word_t tx_mem [DEPTH];
  asu_ptr_t  tx_fifo_read_ptr, tx_fifo_write_ptr;
  logic      tx_lastwr_reg;
  asu_word_t tx_slot_dma_holding [4];
  logic [3:0] tx_full_reg;
  logic      tx_empty, tx_load, tx_uf;
  asu_slot_t tx_slot_reg, tx_lslot;
  logic [3:0] tx_bit_reg;
  logic      tx_act_reg, tx_adv, tx_end;
  asu_word_t tx_sh_reg, tx_src;

  assign tx_empty = tx_fifo_read_ptr == tx_fifo_write_ptr && !tx_lastwr_reg;
  assign tx_end   = tx_bit_reg == (w16 ? 4'hF : 4'h7);
  assign tx_adv   = t_rise && tx_act_reg && tx_end && tx_slot_reg != nsl;
  assign tx_lslot = t_start ? 2'h0 : tx_slot_reg + 2'h1;
  // Loading a new word into the shifter is the FIFO read access
  assign tx_load  = (t_start || tx_adv) && tx_asg[tx_lslot];
  assign tx_uf    = tx_load && !dmaen_reg[tx_lslot] && tx_empty;
  always_comb begin
    if (dmaen_reg[tx_lslot]) begin
      tx_src = tx_slot_dma_holding[tx_lslot];
    end else if (tx_empty) begin
      tx_src = tx_mem[tx_fifo_read_ptr - 4'h1];
    end else begin
      tx_src = tx_mem[tx_fifo_read_ptr];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_txf) tx_mem[tx_fifo_write_ptr] <= wdata;
  end

  logic tx_pop;
  assign tx_pop = tx_load && !dmaen_reg[tx_lslot];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_fifo_read_ptr  <= 4'h0;
      tx_fifo_write_ptr <= 4'h0;
      tx_lastwr_reg     <= 1'b0;
    end else begin
      // No guard against a write into a full FIFO
      if (wr_txf) tx_fifo_write_ptr <= tx_fifo_write_ptr + 4'h1;
      if (tx_uf) begin
        tx_fifo_read_ptr <= tx_fifo_read_ptr - 4'h1;
      end else if (tx_pop) begin
        tx_fifo_read_ptr <= tx_fifo_read_ptr + 4'h1;
      end
      if (wr_txf && !tx_pop) tx_lastwr_reg <= 1'b1;
      else if (tx_pop && !wr_txf) tx_lastwr_reg <= 1'b0;
    end
  end

  // Holding registers keep their word, so an empty one resends it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_reg <= 4'h0;
      for (int i = 0; i < 4; i++) tx_slot_dma_holding[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr && addr == `ASU_OFS_TXDMA0 + 6'(4 * i)) begin
          tx_slot_dma_holding[i] <= wdata;
          tx_full_reg[i]         <= 1'b1;
        end else if (tx_load && dmaen_reg[i] && tx_lslot == 2'(i)) begin
          tx_full_reg[i] <= 1'b0;
        end
      end
    end
  end
  assign tx_dma_req = {4{en}} & dmaen_reg[3:0] & ~tx_full_reg;

  // ------------------------------------------------------------
  // Transmit shifter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_act_reg  <= 1'b0;
      tx_slot_reg <= 2'h0;
      tx_bit_reg  <= 4'h0;
      tx_sh_reg   <= 16'h0000;
    end else if (!en) begin
      tx_act_reg <= 1'b0;
    end else if (t_start || tx_adv) begin
      tx_act_reg  <= 1'b1;
      tx_slot_reg <= tx_lslot;
      tx_bit_reg  <= 4'h0;
      if (tx_load) tx_sh_reg <= w16 ? tx_src : {8'h00, tx_src[7:0]};
    end else if (t_rise && tx_act_reg) begin
      if (tx_end) tx_act_reg <= 1'b0;
      tx_bit_reg <= tx_bit_reg + 4'h1;
      tx_sh_reg  <= {tx_sh_reg[14:0], 1'b0};
    end
  end
  assign serial_tx_data_pin_o  = w16 ? tx_sh_reg[15] : tx_sh_reg[7];
  assign serial_tx_data_pin_oe = tx_act_reg && tx_asg[tx_slot_reg];

  // ------------------------------------------------------------
  // Receive shifter, FIFO and slot holding registers
  // ------------------------------------------------------------
  asu_word_t rx_shift_register;
  asu_slot_t rx_slot_reg;
  logic [3:0] rx_bit_reg;
  logic      rx_act_reg, rx_done, rx_pass, rx_to_fifo, rx_fullf, rx_put;
  asu_word_t rx_word;
  assign rx_done = r_fall && rx_act_reg && rx_bit_reg == (w16 ? 4'hF : 4'h7);
  assign rx_word = w16 ? {rx_shift_register[14:0], rxd}
                       : {8'h00, rx_shift_register[6:0], rxd};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_act_reg        <= 1'b0;
      rx_slot_reg       <= 2'h0;
      rx_bit_reg        <= 4'h0;
      rx_shift_register <= 16'h0000;
    end else if (!en) begin
      rx_act_reg <= 1'b0;
    end else if (r_start) begin
      rx_act_reg  <= 1'b1;
      rx_slot_reg <= 2'h0;
      rx_bit_reg  <= 4'h0;
    end else if (r_fall && rx_act_reg) begin
      // Every slot is shifted in, assigned or not
      rx_shift_register <= rx_word;
      rx_bit_reg        <= rx_done ? 4'h0 : rx_bit_reg + 4'h1;
      if (rx_done) begin
        rx_slot_reg <= rx_slot_reg + 2'h1;
        if (rx_slot_reg == nsl) rx_act_reg <= 1'b0;
      end
    end
  end

  asu_word_t rx_mem [DEPTH];
  asu_ptr_t  rx_fifo_read_ptr, rx_fifo_write_ptr;
  logic      rx_lastwr_reg;
  asu_word_t rx_slot_dma_holding [4];
  logic [3:0] rx_full_reg;
  assign rx_pass    = rx_done && rx_asg[rx_slot_reg];
  assign rx_to_fifo = rx_pass && !dmaen_reg[4 + rx_slot_reg];
  assign rx_fullf   = rx_fifo_read_ptr == rx_fifo_write_ptr && rx_lastwr_reg;
  assign rx_put     = rx_to_fifo && !rx_fullf;

  always_ff @(posedge clk) begin
    if (rx_put) rx_mem[rx_fifo_write_ptr] <= rx_word;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_read_ptr  <= 4'h0;
      rx_fifo_write_ptr <= 4'h0;
      rx_lastwr_reg     <= 1'b0;
    end else begin
      if (rx_put) rx_fifo_write_ptr <= rx_fifo_write_ptr + 4'h1;
      // An empty FIFO is read anyway and hands back stale data
      if (rd_rxf) rx_fifo_read_ptr <= rx_fifo_read_ptr + 4'h1;
      if (rx_put && !rd_rxf) rx_lastwr_reg <= 1'b1;
      else if (rd_rxf && !rx_put) rx_lastwr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_reg <= 4'h0;
      for (int i = 0; i < 4; i++) rx_slot_dma_holding[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (rx_pass && dmaen_reg[4 + i] && rx_slot_reg == 2'(i)) begin
          rx_slot_dma_holding[i] <= rx_word;
          rx_full_reg[i]         <= 1'b1;
        end else if (rd && addr == `ASU_OFS_RXDMA0 + 6'(4 * i)) begin
          rx_full_reg[i] <= 1'b0;
        end
      end
    end
  end
  assign rx_dma_req = dmaen_reg[7:4] & rx_full_reg;

  // ------------------------------------------------------------
  // Sticky error flags and read port
  // ------------------------------------------------------------
  // No interrupt exists here, so errors raise nothing but the flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txu_reg <= 1'b0;
      rxo_reg <= 1'b0;
    end else begin
      if (tx_uf) txu_reg <= 1'b1;
      else if (wr_stat && wdata[`ASU_ST_TXU]) txu_reg <= 1'b0;
      if (rx_to_fifo && rx_fullf) rxo_reg <= 1'b1;
      else if (wr_stat && wdata[`ASU_ST_RXO]) rxo_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (!rd) begin
      rdata <= 16'h0000;
    end else if (addr == `ASU_OFS_RXFIFO) begin
      rdata <= rx_mem[rx_fifo_read_ptr];
    end else if (addr >= `ASU_OFS_RXDMA0 && addr < `ASU_OFS_TXFIFO) begin
      rdata <= rx_slot_dma_holding[addr[3:2] - 2'h1];
    end else if (addr == `ASU_OFS_CTRL) begin
      rdata <= ctrl_reg;
    end else if (addr == `ASU_OFS_DMAEN) begin
      rdata <= {8'h00, dmaen_reg};
    end else if (addr == `ASU_OFS_STAT) begin
      rdata <= {rx_fifo_write_ptr, rx_fifo_read_ptr, 2'h0, rx_fullf,
                rx_fifo_read_ptr == rx_fifo_write_ptr && !rx_lastwr_reg,
                tx_fifo_read_ptr == tx_fifo_write_ptr && tx_lastwr_reg,
                tx_empty, rxo_reg, txu_reg};
    end else if (addr == `ASU_OFS_CLK) begin
      rdata <= {9'h000, flen_reg};
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_tx_push; wr_txf && !tx_pop; endsequence
  sequence s_rx_pop;  rd_rxf && !rx_put; endsequence

  a_txwp_step: assert property (wr_txf |=> tx_fifo_write_ptr == $past(tx_fifo_write_ptr) + 4'h1)
    else $error("tx write pointer did not advance");
  a_txrp_step: assert property (tx_pop && !tx_uf |=> tx_fifo_read_ptr == $past(tx_fifo_read_ptr) + 4'h1)
    else $error("tx read pointer did not advance");
  a_tx_under: assert property (tx_uf |=> txu_reg && tx_fifo_read_ptr == $past(tx_fifo_read_ptr) + 4'hF)
    else $error("underrun did not step back");
  a_tx_full: assert property (s_tx_push ##1 (tx_fifo_read_ptr == tx_fifo_write_ptr) |-> !tx_empty)
    else $error("full tx FIFO reads empty");
  a_rxrp_step: assert property (s_rx_pop |=> rx_fifo_read_ptr == $past(rx_fifo_read_ptr) + 4'h1)
    else $error("rx read pointer did not advance");
  a_rx_over: assert property (rx_to_fifo && rx_fullf |=> rxo_reg && $stable(rx_fifo_write_ptr))
    else $error("overrun not handled");
  a_rxo_sticky: assert property (rxo_reg && !wr_stat |=> rxo_reg)
    else $error("overrun flag dropped");
  a_tx_oe_idle: assert property (!en |=> !serial_tx_data_pin_oe)
    else $error("tx pin driven while disabled");
  a_rxdma_fill: assert property (rx_pass && dmaen_reg[4 + rx_slot_reg] |=> rx_dma_req[$past(rx_slot_reg)])
    else $error("rx holding not requested");
  a_rx_unasg: assert property (rx_done && !rx_asg[rx_slot_reg] |=>
    $stable(rx_fifo_write_ptr) && (rx_full_reg & ~$past(rx_full_reg)) == 4'h0)
    else $error("unassigned slot passed on");
endmodule : asu_datapath

// [sim/asu_codec_model.sv]
// Behavioural PCM codec on the serial pins of the audio data path.
// Assumes the device uses external clocks and short frame syncs.
`timescale 1ns/1ps
module asu_codec_model (
  output logic      sck,
  output logic      fs,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic txd_oe
);
  logic [15:0] tx_bits;
  int          drive_cnt;
  initial begin
    sck = 1'b0;
    fs = 1'b0;
    rxd = 1'b0;
    tx_bits = '0;
    drive_cnt = 0;
  end
  // --------------------------------------------------------------
  // Frame: one-bit sync, then nbits plus one closing bit clock
  // --------------------------------------------------------------
  // Clock stands still outside frames; released data line toggles
  task automatic frame(input logic [15:0] word, input int nbits);
    fs = 1'b1;
    #80 sck = 1'b1;
    #80 sck = 1'b0;
    fs = 1'b0;
    tx_bits = '0;
    drive_cnt = 0;
    for (int k = 0; k <= nbits; k++) begin
      #80 sck = 1'b1;
      rxd = (k < nbits) ? word[nbits-1-k] : ~rxd;
      #80 sck = 1'b0;
      if (txd_oe) begin
        tx_bits = {tx_bits[14:0], txd};
        drive_cnt++;
      end
    end
  endtask : frame
endmodule : asu_codec_model

// [sim/asu_datapath_tb_top.sv]
// Self-checking bench of the audio serial unit data path.
// Assumes asu_cfg.svh offsets and a codec model driving external clocks.
`timescale 1ns/1ps
`include "asu_cfg.svh"
module asu_datapath_tb_top;
  import asu_pkg::*;
  logic       clk, rst_n, wr, rd, txd_o, txd_oe, txd_last;
  logic [5:0] addr;
  asu_word_t  wdata, rdata, st;
  logic [3:0] txq, rxq;
  logic       tck_o, tck_oe, tfs_o, tfs_oe, rck_o, rck_oe, rfs_o, rfs_oe;
  wire        sck, fs, rxd, txd_line;
  int         num_errors, n_checks, cycles;
  initial begin
    clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
    txd_last = 1'b0; num_errors = 0; n_checks = 0; cycles = 0;
  end
  always #5 clk = ~clk;
  always @(posedge clk) if (txd_oe) txd_last <= txd_o;
  // Released tx line shows inverse of last bit, never a lucky match
  assign txd_line = txd_oe ? txd_o : ~txd_last;
  asu_datapath DUT (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_shift_clock_pin_i(sck), .tx_shift_clock_pin_o(tck_o),
    .tx_shift_clock_pin_oe(tck_oe), .tx_frame_sync_pin_i(fs), .tx_frame_sync_pin_o(tfs_o),
    .tx_frame_sync_pin_oe(tfs_oe), .rx_shift_clock_pin_i(sck), .rx_shift_clock_pin_o(rck_o),
    .rx_shift_clock_pin_oe(rck_oe), .rx_frame_sync_pin_i(fs), .rx_frame_sync_pin_o(rfs_o),
    .rx_frame_sync_pin_oe(rfs_oe), .serial_tx_data_pin_o(txd_o),
    .serial_tx_data_pin_oe(txd_oe), .serial_rx_data_pin_i(rxd),
    .tx_dma_req(txq), .rx_dma_req(rxq));
  asu_codec_model codec (.sck(sck), .fs(fs), .rxd(rxd), .txd(txd_line), .txd_oe(txd_oe));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [5:0] a, input asu_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Let the write settle before anyone looks at its effect
    #1;
  endtask : bus_wr
  task automatic bus_rd(input logic [5:0] a, output asu_word_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_tx_fifo;
    logic [7:0] rxw [4];
    rxw = '{8'h81, 8'h42, 8'h18, 8'hE7};
    bus_wr(`ASU_OFS_CTRL, 16'h0001);
    bus_wr(`ASU_OFS_TXFIFO, 16'h00A5);
    bus_wr(`ASU_OFS_TXFIFO, 16'h003C);
    codec.frame(16'h0081, 8); chk(codec.tx_bits, 16'h00A5);
    codec.frame(16'h0042, 8); chk(codec.tx_bits, 16'h003C);
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'h0005, 16'h0004);
    codec.frame(16'h0018, 8); chk(codec.tx_bits, 16'h003C);
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'h0001, 16'h0001);
    codec.frame(16'h00E7, 8);
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'hF001, 16'h4001);
    bus_wr(`ASU_OFS_STAT, 16'h0001);
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'h0001, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      bus_rd(`ASU_OFS_RXFIFO, st); chk(st & 16'h00FF, {8'h00, rxw[i]});
    end
  endtask : test_tx_fifo
  task automatic test_rx_overrun;
    bus_wr(`ASU_OFS_CTRL, 16'h0003);
    for (int i = 0; i < 17; i++) codec.frame(16'h1000 + 16'(i) * 16'h0111, 16);
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'hFF22, 16'h4422);
    for (int i = 0; i < 16; i++) begin
      bus_rd(`ASU_OFS_RXFIFO, st); chk(st, 16'h1000 + 16'(i) * 16'h0111);
    end
  endtask : test_rx_overrun
  task automatic test_dma_normal;
    bus_wr(`ASU_OFS_CTRL, 16'h0001);
    bus_wr(`ASU_OFS_DMAEN, 16'h0011);
    codec.frame(16'h005A, 8); chk({12'h000, rxq}, 16'h0001);
    codec.frame(16'h00C3, 8);
    bus_rd(`ASU_OFS_RXDMA0, st); chk(st & 16'h00FF, 16'h00C3);
    chk({12'h000, rxq}, 16'h0000);
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'h0010, 16'h0010);
    chk({12'h000, txq}, 16'h0001);
    bus_wr(`ASU_OFS_TXDMA0, 16'h0096); chk({12'h000, txq}, 16'h0000);
    codec.frame(16'h0000, 8); chk(codec.tx_bits, 16'h0096);
    chk({12'h000, txq}, 16'h0001);
    codec.frame(16'h0000, 8); chk(codec.tx_bits, 16'h0096);
  endtask : test_dma_normal
  task automatic test_internal_clock;
    int   n_tog, n_fs, n_diff;
    logic prev;
    n_tog = 0;
    n_fs = 0;
    n_diff = 0;
    bus_wr(`ASU_OFS_CTRL, 16'h0031);
    chk({14'h0000, rck_oe, rfs_oe}, 16'h0003);
    bus_wr(`ASU_OFS_CTRL, 16'h0039);
    chk({12'h000, tck_oe, tfs_oe, rck_oe, rfs_oe}, 16'h000C);
    prev = tck_o;
    // One whole frame, so the counts do not depend on phase
    repeat (2 * (`ASU_FLEN_RST + 1) * `ASU_BCLK_HALF) begin
      @(posedge clk);
      #1;
      if (tck_o !== prev) n_tog++;
      if (tfs_o === 1'b1) n_fs++;
      if (rck_o !== tck_o || rfs_o !== tfs_o) n_diff++;
      prev = tck_o;
    end
    chk(16'(n_tog), 16'h0040);
    chk(16'(n_fs), 16'h0010);
    chk(16'(n_diff), 16'h0000);
  endtask : test_internal_clock
  task automatic test_network;
    // Fresh start: earlier underruns leave a resend word in the tx FIFO
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus_wr(`ASU_OFS_DMAEN, 16'h0000);
    bus_wr(`ASU_OFS_CTRL, 16'h1245);
    bus_wr(`ASU_OFS_TXFIFO, 16'h0011);
    bus_wr(`ASU_OFS_TXFIFO, 16'h0022);
    codec.frame(16'hABCD, 16); chk(16'(codec.drive_cnt), 16'h0008);
    chk(codec.tx_bits & 16'h00FF, 16'h0011);
    bus_rd(`ASU_OFS_RXFIFO, st); chk(st & 16'h00FF, 16'h00AB);
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'h0010, 16'h0010);
    codec.frame(16'h1234, 16); chk(codec.tx_bits & 16'h00FF, 16'h0022);
    bus_rd(`ASU_OFS_RXFIFO, st); chk(st & 16'h00FF, 16'h0012);
    for (int i = 0; i < 16; i++) bus_wr(`ASU_OFS_TXFIFO, 16'(i));
    bus_rd(`ASU_OFS_STAT, st); chk(st & 16'h000C, 16'h0008);
  endtask : test_network
  // --------------------------------------------------------------
  // Main sequence and hang guard
  // --------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    test_tx_fifo();
    test_rx_overrun();
    test_dma_normal();
    test_internal_clock();
    test_network();
    complete_run();
  end
endmodule : asu_datapath_tb_top
